// ===== hdl/arb_pkg.sv
// Purpose: Constants for the bus arbitration and external-master block
// Assumes: One bus clock, synchronous active-high reset
// Notes: Chip-select compare uses base and mask per select
package arb_pkg;
   localparam int CS_COUNT = 8;
   localparam int DRAM_BANKS = 2;
   localparam int BE_WIDTH = 4;
   localparam int CAS_WIDTH = 4;
   localparam int ADDR_WIDTH = 32;
   localparam int WAIT_WIDTH = 4;
   localparam int CMP_LSB = 16;
   // Cycles from start sample to select assertion (falling edge of cycle four)
   localparam logic [3:0] DECODE_CYCLES = 4'h2;
   // Acknowledge follows the select by this many cycles plus wait states
   localparam logic [3:0] ACK_CYCLES = 4'h1;
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LINE = 2'h3;

   typedef enum logic [3:0] {
      ARB_RESET = 4'b0001,
      ARB_IMPLICIT = 4'b0010,
      ARB_EXPLICIT = 4'b0100,
      ARB_EXTERNAL = 4'b1000
   } arb_state_e;

   typedef enum logic [3:0] {
      XM_IDLE = 4'b0001,
      XM_DECODE = 4'b0010,
      XM_SELECT = 4'b0100,
      XM_ACK = 4'b1000
   } xm_state_e;
endpackage

// ===== hdl/bus_arbitration_ext_master.sv
// Purpose: Bus arbitration handshake and external-master memory control
// Assumes: Own bus cycles run elsewhere; this block tracks them by handshake
// Notes: Falling-edge outputs are modelled as full-cycle registers
`timescale 1ns/100ps
//
// Contract
// R01 - Request output asserted when bus needed
// R02 - Request drops at access start, none pending
// R03 - Grant lets device take bus next edge
// R04 - Grant removal: release after current transfer
// R05 - Arbiter waits for driven and grant negated
// R06 - Driven output asserted while actively mastering
// R07 - Lost mid-transfer: finish, negate, three-state
// R08 - Lost while idle: three-state next edge
// R09 - External hold blocks own bus requests
// R10 - Drive selects, strobes, acknowledge for external
// R11 - Start or address strobe begins decoding
// R12 - Select only with alternate-master enable set
// R13 - DRAM strobes only with alternate enable
// R14 - External drives one strobe, never both
// R15 - Read high, write low, same sequence
// R16 - Internal acknowledge after programmed wait states
// R17 - Select and byte enables in cycle four
// R18 - Acknowledge asserted in cycle five
// R19 - Cycle six: drop acknowledge, then selects (code negates both at the same edge)
// R20 - May request during running external cycle
// R21 - Implicit master keeps bus three-stated
// R22 - Reset state from any; then by grant
// R23 - Latch address at start, shared compare
module bus_arbitration_ext_master
   import arb_pkg::*;
#(
   parameter int N_CS = CS_COUNT
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_watchdog_rst,
   input wire logic i_arb_grant_in_n,
   input wire logic i_internal_req,
   input wire logic i_internal_more_pending,
   input wire logic i_own_transfer_done,
   input wire logic i_transfer_start_n,
   input wire logic i_address_strobe_n,
   input wire logic i_transfer_in_progress_n,
   input wire logic i_read_write,
   input wire logic [1:0] i_transfer_type,
   input wire logic [2:0] i_transfer_modifier,
   input wire logic [1:0] i_transfer_size,
   input wire logic [ADDR_WIDTH-1:0] i_addr,
   input wire logic [N_CS*16-1:0] i_cs_base,
   input wire logic [N_CS*16-1:0] i_chip_select_mask_reg,
   input wire logic [N_CS-1:0] i_alternate_master_enable,
   input wire logic [N_CS-1:0] i_cs_auto_ack,
   input wire logic [N_CS-1:0] i_cs_byte_enable_on,
   input wire logic [N_CS*WAIT_WIDTH-1:0] i_cs_wait_states,
   input wire logic [DRAM_BANKS*16-1:0] i_dram_base,
   input wire logic [DRAM_BANKS*16-1:0] i_dram_mask_reg,
   input wire logic [DRAM_BANKS-1:0] i_dram_alternate_master_enable,
   output logic o_arb_request_out_n,
   output logic o_bus_driven_out_n,
   output logic o_bus_oe_n,
   output logic o_start_own_access,
   output logic [N_CS-1:0] o_chip_select_n,
   output logic [BE_WIDTH-1:0] o_byte_enable_strobe_n,
   output logic o_output_enable_n,
   output logic [DRAM_BANKS-1:0] o_row_strobe_n,
   output logic [CAS_WIDTH-1:0] o_col_strobe_n,
   output logic o_transfer_ack_out_n,
   output logic o_transfer_ack_oe_n,
   output logic o_ext_read_write
);

   function automatic logic addr_hit(input logic [15:0] base, input logic [15:0] mask,
                                     input logic [ADDR_WIDTH-1:0] a);
      addr_hit = ((a[ADDR_WIDTH-1:CMP_LSB] ^ base) & ~mask) == 16'h0000;
   endfunction

   function automatic logic [BE_WIDTH-1:0] lane_mask(input logic [1:0] sz, input logic [1:0] a);
      unique case (sz)
         SIZE_BYTE: lane_mask = 4'h8 >> a;
         SIZE_WORD: lane_mask = a[1] ? 4'h3 : 4'hc;
         SIZE_LONG: lane_mask = 4'hf;
         SIZE_LINE: lane_mask = 4'hf;
      endcase
   endfunction

   logic grant_s1_reg, grant_s2_reg, ts_s1_reg, ts_s2_reg, as_s1_reg, as_s2_reg;
   logic tip_s1_reg, tip_s2_reg;
   logic grant, ext_start;
   arb_state_e arb_reg;
   xm_state_e xm_reg;
   logic [ADDR_WIDTH-1:0] addr_reg;
   logic rw_reg;
   logic [1:0] size_reg;
   logic [N_CS-1:0] cs_hit_reg;
   logic [DRAM_BANKS-1:0] dram_hit_reg;
   logic auto_ack_reg;
   logic [3:0] cnt_reg;
   logic [WAIT_WIDTH-1:0] ws_reg;
   logic own_busy_reg;

   // Two-stage synchronisers for the grant, start, address strobe and in-progress pins
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         grant_s1_reg <= 1'b0;
         grant_s2_reg <= 1'b0;
         ts_s1_reg <= 1'b1;
         ts_s2_reg <= 1'b1;
         as_s1_reg <= 1'b1;
         as_s2_reg <= 1'b1;
         tip_s1_reg <= 1'b1;
         tip_s2_reg <= 1'b1;
      end else begin
         grant_s1_reg <= ~i_arb_grant_in_n;
         grant_s2_reg <= grant_s1_reg;
         ts_s1_reg <= i_transfer_start_n;
         ts_s2_reg <= ts_s1_reg;
         as_s1_reg <= i_address_strobe_n;
         as_s2_reg <= as_s1_reg;
         tip_s1_reg <= i_transfer_in_progress_n;
         tip_s2_reg <= tip_s1_reg;
      end
   end

   assign grant = grant_s2_reg; // R03 R09
   // External relies on only one strobe per cycle
   assign ext_start = (~ts_s2_reg | ~as_s2_reg) && arb_reg == ARB_EXTERNAL; // R11 R14

   // Arbitration state machine
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_watchdog_rst) begin
         arb_reg <= ARB_RESET; // R22
      end else begin
         unique case (arb_reg)
            ARB_RESET: arb_reg <= grant ? ARB_IMPLICIT : ARB_EXTERNAL; // R22
            ARB_IMPLICIT: begin
               if (!grant) begin
                  arb_reg <= ARB_EXTERNAL; // R08
               end else if (i_internal_req) begin
                  arb_reg <= ARB_EXPLICIT; // R03
               end
            end
            ARB_EXPLICIT: begin
               if (!grant && !own_busy_reg) begin
                  arb_reg <= ARB_EXTERNAL; // R04 R07 R08
               end
            end
            ARB_EXTERNAL: arb_reg <= grant ? ARB_IMPLICIT : ARB_EXTERNAL; // R09
         endcase
      end
   end

   // Own transfer tracking
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_watchdog_rst) begin
         own_busy_reg <= 1'b0;
         o_start_own_access <= 1'b0;
      end else begin
         o_start_own_access <= 1'b0;
         if (own_busy_reg && i_own_transfer_done) begin
            own_busy_reg <= 1'b0; // R07
         end else if (!own_busy_reg && grant && i_internal_req &&
                      (arb_reg == ARB_IMPLICIT || arb_reg == ARB_EXPLICIT)) begin
            own_busy_reg <= 1'b1;
            o_start_own_access <= 1'b1;
         end
      end
   end

   // Request, driven and bus enable outputs
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_watchdog_rst) begin
         o_arb_request_out_n <= 1'b1;
         o_bus_driven_out_n <= 1'b1;
         o_bus_oe_n <= 1'b1;
      end else begin
         if (o_start_own_access && !i_internal_more_pending) begin
            o_arb_request_out_n <= 1'b1; // R02
         end else if (i_internal_req) begin
            o_arb_request_out_n <= 1'b0; // R01 R20
         end
         o_bus_driven_out_n <= ~(arb_reg == ARB_EXPLICIT && (grant || own_busy_reg)); // R06 R07 R21
         o_bus_oe_n <= ~(arb_reg == ARB_EXPLICIT && (grant || own_busy_reg)); // R07 R08 R21
      end
   end

   // External-master access sequencer
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_watchdog_rst) begin
         xm_reg <= XM_IDLE;
         addr_reg <= '0;
         rw_reg <= 1'b1;
         size_reg <= SIZE_LONG;
         cs_hit_reg <= '0;
         dram_hit_reg <= '0;
         auto_ack_reg <= 1'b0;
         cnt_reg <= 4'h0;
         ws_reg <= '0;
      end else begin
         unique case (xm_reg)
            XM_IDLE: begin
               if (ext_start) begin
                  addr_reg <= i_addr; // R23
                  auto_ack_reg <= 1'b0;
                  rw_reg <= i_read_write; // R15
                  size_reg <= i_transfer_size;
                  for (int k = 0; k < N_CS; k++) begin
                     cs_hit_reg[k] <= addr_hit(i_cs_base[k*16 +: 16], i_chip_select_mask_reg[k*16 +: 16],
                                               i_addr) & i_alternate_master_enable[k]; // R12 R23
                  end
                  for (int k = 0; k < DRAM_BANKS; k++) begin
                     dram_hit_reg[k] <= addr_hit(i_dram_base[k*16 +: 16], i_dram_mask_reg[k*16 +: 16],
                                                 i_addr) & i_dram_alternate_master_enable[k]; // R13
                  end
                  cnt_reg <= DECODE_CYCLES;
                  xm_reg <= XM_DECODE; // R11
               end
            end
            XM_DECODE: begin
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == 4'h1) begin
                  xm_reg <= XM_SELECT; // R17
                  auto_ack_reg <= |(cs_hit_reg & i_cs_auto_ack);
                  ws_reg <= '0;
                  for (int k = 0; k < N_CS; k++) begin
                     if (cs_hit_reg[k]) begin
                        ws_reg <= i_cs_wait_states[k*WAIT_WIDTH +: WAIT_WIDTH]; // R16
                     end
                  end
                  cnt_reg <= ACK_CYCLES - 4'h1; // R18
               end
            end
            XM_SELECT: begin
               if (cnt_reg != 4'h0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else if (ws_reg != '0) begin
                  ws_reg <= ws_reg - 1'b1; // R16
               end else begin
                  xm_reg <= XM_ACK; // R18
               end
            end
            XM_ACK: xm_reg <= XM_IDLE; // R19
         endcase
      end
   end

   // Memory control outputs for external-master accesses
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_watchdog_rst) begin
         o_chip_select_n <= '1;
         o_byte_enable_strobe_n <= '1;
         o_output_enable_n <= 1'b1;
         o_row_strobe_n <= '1;
         o_col_strobe_n <= '1;
         o_transfer_ack_out_n <= 1'b1;
         o_transfer_ack_oe_n <= 1'b1;
         o_ext_read_write <= 1'b1;
      end else begin
         if (xm_reg == XM_DECODE && cnt_reg == 4'h1) begin
            o_chip_select_n <= ~cs_hit_reg; // R10 R12 R17
            o_byte_enable_strobe_n <= |(cs_hit_reg & i_cs_byte_enable_on) ?
                                      ~lane_mask(size_reg, addr_reg[1:0]) : '1; // R12 R17
            o_output_enable_n <= ~(rw_reg && |cs_hit_reg); // R15
            o_row_strobe_n <= ~dram_hit_reg; // R13
            o_col_strobe_n <= |dram_hit_reg ? ~lane_mask(size_reg, addr_reg[1:0]) : '1; // R13
            o_ext_read_write <= rw_reg;
         end else if (xm_reg == XM_ACK || xm_reg == XM_IDLE) begin
            o_chip_select_n <= '1; // R19
            o_byte_enable_strobe_n <= '1; // R19
            o_output_enable_n <= 1'b1;
            o_row_strobe_n <= '1;
            o_col_strobe_n <= '1;
         end
         o_transfer_ack_out_n <= ~(xm_reg == XM_SELECT && cnt_reg == 4'h0 && ws_reg == '0 &&
                                   auto_ack_reg); // R16 R18 R19
         o_transfer_ack_oe_n <= ~(xm_reg != XM_IDLE && auto_ack_reg); // R10
      end
   end

   // Checks
   chk_driven_needs_master: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R06
      !o_bus_driven_out_n |-> $past(arb_reg) == ARB_EXPLICIT)
      else $error("bus driven without explicit mastership");
   chk_idle_loss_release: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_watchdog_rst) // R08
      (arb_reg == ARB_EXPLICIT && !grant && !own_busy_reg) |=> o_bus_oe_n)
      else $error("bus not released after idle loss");
   chk_busy_keeps_bus: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_watchdog_rst) // R07
      (arb_reg == ARB_EXPLICIT && own_busy_reg) |=> !o_bus_driven_out_n)
      else $error("bus dropped during own transfer");
   chk_implicit_tristate: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_watchdog_rst) // R21
      (arb_reg == ARB_IMPLICIT) |=> o_bus_oe_n)
      else $error("implicit master drove bus");
   chk_ack_after_select: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_watchdog_rst) // R18
      $fell(o_transfer_ack_out_n) |-> $past(o_chip_select_n) != '1)
      else $error("acknowledge without chip select");
   chk_ack_one_cycle: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_watchdog_rst) // R19
      !o_transfer_ack_out_n |=> o_transfer_ack_out_n ##1 (o_chip_select_n == '1))
      else $error("acknowledge or select not negated");
   chk_select_enabled: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
      (~o_chip_select_n & ~i_alternate_master_enable) == '0)
      else $error("select without alternate enable");
   chk_start_decode: assert property (@(posedge i_ref_clk) disable iff (i_rst || i_watchdog_rst) // R11
      (ext_start && xm_reg == XM_IDLE) |=> xm_reg == XM_DECODE ##2 xm_reg == XM_SELECT)
      else $error("decode not started");
   chk_reset_state: assert property (@(posedge i_ref_clk) // R22
      i_rst |=> arb_reg == ARB_RESET && o_bus_driven_out_n)
      else $error("reset state not entered");
   cov_external_ack: cover property (@(posedge i_ref_clk) disable iff (i_rst) $fell(o_transfer_ack_out_n));
   cov_explicit: cover property (@(posedge i_ref_clk) disable iff (i_rst) arb_reg == ARB_EXPLICIT);
   cov_loss_busy: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      arb_reg == ARB_EXPLICIT && !grant && own_busy_reg);

endmodule

// ===== verif/bus_arbitration_ext_master_test.sv
// Purpose: Self-checking bench for arbitration and external-master control
// Assumes: Partner model plays the external master
// Notes: Table rows cover decode; arbitration cases by hand
`timescale 1ns/100ps
module bus_arbitration_ext_master_test
   import arb_pkg::*;
;
   typedef struct {logic [31:0] a; logic [1:0] sz; logic rd; logic sa; logic [7:0] cs; logic [3:0] be; int ack;
      logic [5:0] dr;} row_s;
   logic clk = 1'b0, rst = 1'b1, wdog = 1'b0, hold = 1'b0, go = 1'b0, sa = 1'b0, rd = 1'b0;
   logic req = 1'b0, done = 1'b0, more = 1'b0;
   logic [127:0] cmask = 128'h0;
   logic [7:0] am = 8'hfb, aack = 8'hff, beon = 8'hff;
   logic [31:0] wst = 32'h000f_0020;
   logic [1:0] dam = 2'h1;
   logic [3:0] cas_n;
   logic aoe_n;
   logic [31:0] a = 32'h0;
   logic [1:0] sz = 2'h0;
   logic grant_n, ts_n, as_n, tip_n, rw, req_n, drv_n, boe_n, st, ack_n, xrw, oe_n;
   logic [1:0] xsz, ras_n;
   logic [31:0] xa;
   logic [7:0] cs_n;
   logic [3:0] be_n;
   int num_errors = 0;
   int total_checks = 0;
   row_s rows [9];

   bus_arbitration_ext_master dut (
      .i_ref_clk(clk), .i_rst(rst), .i_watchdog_rst(wdog), .i_arb_grant_in_n(grant_n),
      .i_internal_req(req), .i_internal_more_pending(more), .i_own_transfer_done(done),
      .i_transfer_start_n(ts_n), .i_address_strobe_n(as_n), .i_transfer_in_progress_n(tip_n),
      .i_read_write(rw), .i_transfer_type(2'h0), .i_transfer_modifier(3'h0), .i_transfer_size(xsz),
      .i_addr(xa), .i_cs_base(128'h8000_7000_6000_5000_4000_3000_2000_1000),
      .i_chip_select_mask_reg(cmask), .i_alternate_master_enable(am), .i_cs_auto_ack(aack),
      .i_cs_byte_enable_on(beon), .i_cs_wait_states(wst), .i_dram_base(32'ha000_9000),
      .i_dram_mask_reg(32'h0), .i_dram_alternate_master_enable(dam), .o_arb_request_out_n(req_n),
      .o_bus_driven_out_n(drv_n), .o_bus_oe_n(boe_n), .o_start_own_access(st), .o_chip_select_n(cs_n),
      .o_byte_enable_strobe_n(be_n), .o_output_enable_n(oe_n), .o_row_strobe_n(ras_n), .o_col_strobe_n(cas_n),
      .o_transfer_ack_out_n(ack_n), .o_transfer_ack_oe_n(aoe_n), .o_ext_read_write(xrw)
   );
   ext_master_model partner (
      .i_ref_clk(clk), .i_hold(hold), .i_go(go), .i_as(sa), .i_rd(rd), .i_a(a), .i_sz(sz), .i_ack_n(ack_n),
      .o_grant_n(grant_n), .o_ts_n(ts_n), .o_as_n(as_n), .o_tip_n(tip_n), .o_rw(rw), .o_sz(xsz), .o_a(xa)
   );

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Bounded wait: 0 driven, 1 bus enable, 2 own start
   task automatic wait_for(input int sel, input logic lvl, input int bound);
      logic v;
      for (int n = 0; n <= bound; n++) begin
         v = (sel == 0) ? drv_n : (sel == 1) ? boe_n : st;
         if (v === lvl) begin
            return;
         end
         tick(1);
      end
      num_errors++;
      $display("[ERR] %0t got=%h exp=%h", $time, v, lvl);
      results();
   endtask
   // One external access, watched for 32 cycles
   task automatic access(input row_s r);
      int tc = -1, ta = -1, na = 0, nc = 0;
      logic ol = 1'b0, rl = 1'b0;
      logic [7:0] cv = 8'hff;
      logic [3:0] bv = 4'hf;
      logic [5:0] dv = 6'h3f;
      logic ao = 1'b0;
      a = r.a;
      sz = r.sz;
      rd = r.rd;
      sa = r.sa;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (int c = 0; c < 32; c++) begin
         tick(1);
         if (cs_n !== 8'hff && tc < 0) begin
            tc = c;
            cv = cs_n;
            bv = be_n;
         end
         nc += int'(cs_n !== 8'hff);
         ta = (ack_n === 1'b0 && ta < 0) ? c : ta;
         na += int'(ack_n === 1'b0);
         ol |= (oe_n === 1'b0);
         rl |= (ras_n[1] === 1'b0);
         if (ras_n !== 2'b11 && dv === 6'h3f) begin
            dv = {ras_n, cas_n};
         end
         ao |= (aoe_n === 1'b0);
      end
      chk(cv, r.cs);
      chk(bv, r.be);
      chk(rl, !r.dr[5]);
      chk(dv, r.dr);
      chk(ao, r.ack >= 0);
      chk(aoe_n, 1'b1);
      if (r.ack < 0) begin
         chk(na, 0);
      end else begin
         // Two sync stages ahead of the take
         chk(tc, DECODE_CYCLES + 2);
         chk(ta - tc, ACK_CYCLES + r.ack);
         chk(na, 1);
         chk(nc, ACK_CYCLES + r.ack + 1);
         chk(ol, r.rd);
         chk(xrw, r.rd);
      end
   endtask

   initial begin
      rows[0] = '{32'h1000_0000, SIZE_LONG, 1'b1, 1'b0, 8'hfe, 4'h0, 0, 6'h3f};
      rows[1] = '{32'h1000_0003, SIZE_BYTE, 1'b0, 1'b1, 8'hfe, 4'he, 0, 6'h3f};
      rows[2] = '{32'h2000_0002, SIZE_WORD, 1'b1, 1'b0, 8'hfd, 4'hc, 2, 6'h3f};
      rows[3] = '{32'h2000_0001, SIZE_BYTE, 1'b1, 1'b1, 8'hfd, 4'hb, 2, 6'h3f};
      rows[4] = '{32'h4000_0000, SIZE_WORD, 1'b0, 1'b0, 8'hf7, 4'h3, 0, 6'h3f};
      rows[5] = '{32'h5000_0000, SIZE_LINE, 1'b0, 1'b0, 8'hef, 4'h0, 15, 6'h3f};
      rows[6] = '{32'h3000_0000, SIZE_LONG, 1'b1, 1'b0, 8'hff, 4'hf, -1, 6'h3f};
      rows[7] = '{32'ha000_0000, SIZE_LONG, 1'b0, 1'b0, 8'hff, 4'hf, -1, 6'h3f};
      rows[8] = '{32'h9000_0003, SIZE_BYTE, 1'b1, 1'b0, 8'hff, 4'hf, -1, 6'h2e};
      tick(10);
      rst = 1'b0;
      tick(6);
      chk(drv_n, 1'b1);
      chk(boe_n, 1'b1);
      chk(req_n, 1'b1);
      hold = 1'b1;
      tick(6);
      $display("reset test done");
      foreach (rows[i]) begin
         chk(drv_n, 1'b1);
         access(rows[i]);
      end
      $display("table test done");
      cmask[15:0] = 16'h0fff;
      beon = 8'hfe;
      access(row_s'{32'h1800_0000, SIZE_LONG, 1'b1, 1'b0, 8'hfe, 4'hf, 0, 6'h3f});
      aack = 8'hfe;
      access(row_s'{32'h1000_0000, SIZE_LONG, 1'b0, 1'b1, 8'hfe, 4'hf, -1, 6'h3f});
      am = 8'hff;
      dam = 2'h3;
      aack = 8'hff;
      beon = 8'hff;
      access(row_s'{32'h3000_0002, SIZE_BYTE, 1'b1, 1'b0, 8'hfb, 4'hd, 0, 6'h3f});
      access(row_s'{32'ha000_0001, SIZE_WORD, 1'b0, 1'b1, 8'hff, 4'hf, -1, 6'h13});
      $display("config test done");
      req = 1'b1;
      tick(6);
      chk(req_n, 1'b0);
      chk(drv_n, 1'b1);
      hold = 1'b0;
      wait_for(2, 1'b1, 8);
      req = 1'b0;
      wait_for(0, 1'b0, 2);
      chk(boe_n, 1'b0);
      tick(3);
      chk(req_n, 1'b1);
      hold = 1'b1;
      tick(6);
      chk(drv_n, 1'b0);
      done = 1'b1;
      tick(1);
      done = 1'b0;
      wait_for(0, 1'b1, 4);
      chk(boe_n, 1'b1);
      $display("own access test done");
      hold = 1'b0;
      req = 1'b1;
      more = 1'b1;
      wait_for(2, 1'b1, 10);
      req = 1'b0;
      tick(3);
      chk(drv_n, 1'b0);
      chk(req_n, 1'b0);
      more = 1'b0;
      wdog = 1'b1;
      tick(1);
      chk(drv_n, 1'b1);
      chk(req_n, 1'b1);
      wdog = 1'b0;
      tick(3);
      req = 1'b1;
      wait_for(2, 1'b1, 10);
      req = 1'b0;
      done = 1'b1;
      tick(1);
      done = 1'b0;
      tick(3);
      hold = 1'b1;
      wait_for(1, 1'b1, 4);
      $display("idle loss test done");
      results();
   end
endmodule

// ===== verif/ext_master_model.sv
// Purpose: External master and arbiter facing the device
// Assumes: Drives on the rising edge of the bus clock
// Notes: Ends its cycle on ack or after a fixed bound
`timescale 1ns/100ps
module ext_master_model (
   input wire logic i_ref_clk,
   input wire logic i_hold,
   input wire logic i_go,
   input wire logic i_as,
   input wire logic i_rd,
   input wire logic [31:0] i_a,
   input wire logic [1:0] i_sz,
   input wire logic i_ack_n,
   output logic o_grant_n,
   output logic o_ts_n = 1'b1,
   output logic o_as_n = 1'b1,
   output logic o_tip_n = 1'b1,
   output logic o_rw = 1'b0,
   output logic [1:0] o_sz = 2'h0,
   output logic [31:0] o_a = 32'h0
);
   logic busy_reg = 1'b0;
   logic [4:0] age_reg = 5'h0;
   // Grant held off while asked for or own cycle runs
   assign o_grant_n = i_hold | busy_reg;
   always @(posedge i_ref_clk) begin
      o_ts_n <= 1'b1;
      o_as_n <= 1'b1;
      age_reg <= age_reg + 5'h1;
      if (!busy_reg && i_go) begin
         busy_reg <= 1'b1;
         age_reg <= 5'h0;
         o_ts_n <= i_as;
         o_as_n <= !i_as;
         o_tip_n <= 1'b0;
         o_rw <= i_rd;
         o_sz <= i_sz;
         o_a <= i_a;
      end else if (busy_reg && (!i_ack_n || age_reg == 5'h14)) begin
         // Released lines show the inverse of the last value
         busy_reg <= 1'b0;
         o_tip_n <= 1'b1;
         o_rw <= !o_rw;
         o_sz <= ~o_sz;
         o_a <= ~o_a;
      end
   end
endmodule
